// ---- hw/mc_pkg.sv ----
// What this block does
// - bit 0 sets at T3 on A-register parity error while allow-A latch on
// - allow-A sets at P1 on chosen A-source decodes, clears at T1 if suppressed
// - suppress-A blocks further A checks until D is gated to the A bus
// - bit 1 sets at T3 on any B-register parity error
// - bit 2 sets at T3 on storage address parity error with allow-write active
// - bit 3 sets at T2 on control register parity error
// - bit 4 sets at T2 on sense latch or next-address parity error
// - bit 5 flags a parity error on the control store address register
// - bit 6 sets on R-register error, or protect stack error when fitted
// - bit 7 sets at T4 on an arithmetic unit check
// - any newly set check bit sets first-check latch when process mode selected
// - check pulse needs priority off, no switch W/X, first-check on, malfunction unsuppressed
// - check latches clear at P4 while the check reset line is active, except bits a new error sets in that cycle
// - check entry forces address 0004; routine tests mask bits 5, 6, 1
// - routine stores check bits at 0080; restoring D last clears suppress-A
// - first check pulse arms second-error stop; repeat sets hard stop; mask bit 1 disarms
// - each priority order sets one low address bit; selector sets bits 4, 6, 7
// - machine reset overrides all, sets parity-position bit, forcing address 0000
// - wrap entry needs no priority, no switch gating, no higher pulse; mask bit 2 ignores
// - share stacking latch cannot set while mask bit 6 is on
// - mask bit 5 blocks selector and share requests
// - any pulse sets any-priority at T1; next T3 sets priority latch blocking pulses
// - W, X and parity-position parity bits must be odd, else bit 5 at T2
package mc_pkg;

   // -------------------------------------------------------------
   // register map (byte addresses on the bus)
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_CAPTURE = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_STACK = 8'h0c;

   localparam int CTRL_PROCESS = 0;
   localparam int CTRL_SUPPRESS_MALF = 1;
   localparam logic [1:0] CONTROL_RESET = 2'h1;

   localparam int STAT_FIRST = 0;
   localparam int STAT_SECOND = 1;
   localparam int STAT_HARD = 2;
   localparam int STAT_ANY_PRIO = 3;
   localparam int STAT_PRIO = 4;
   localparam int STAT_ALLOW_A = 5;
   localparam int STAT_SUPPRESS_A = 6;
   localparam int STAT_MANUAL = 7;

   // -------------------------------------------------------------
   // machine check bit positions, bit 0 is the most significant
   // -------------------------------------------------------------
   localparam int MC_A = 0;
   localparam int MC_B = 1;
   localparam int MC_SAR = 2;
   localparam int MC_CTRL = 3;
   localparam int MC_SENSE = 4;
   localparam int MC_CSAR = 5;
   localparam int MC_R = 6;
   localparam int MC_ALU = 7;
   localparam logic [7:0] MC_RESET = 8'h00;

   // priority mask bits, same numbering
   localparam int MASK_CHECK_HELD = 1;
   localparam int MASK_WRAP = 2;
   localparam int MASK_SELECTOR = 5;
   localparam int MASK_SHARE = 6;

   // priority levels
   localparam int LVL_CHECK = 1;
   localparam int LVL_SELECTOR = 2;
   localparam int LVL_WRAP = 4;
   localparam int LVL_SHARE = 8;

   // main storage word that the check routine fills
   localparam logic [15:0] MC_STORE_ADDR = 16'h0080;

   // low address byte forced by each level, bit 0 = 8'h80
   localparam logic [7:0] X_LEVEL1 = 8'h04;
   localparam logic [7:0] X_LEVEL2 = 8'h0b;
   localparam logic [7:0] X_LEVEL3 = 8'h80;
   localparam logic [7:0] X_LEVEL4 = 8'h20;
   localparam logic [7:0] X_LEVEL5 = 8'h40;
   localparam logic [7:0] X_LEVEL6 = 8'h10;
   localparam logic [7:0] X_LEVEL7 = 8'h08;
   localparam logic [7:0] X_LEVEL8 = 8'h02;
   localparam logic [7:0] X_MACHINE_RESET = 8'h00;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic p1;
      logic t1;
      logic t2;
      logic t3;
      logic t4;
      logic p4;
   } phase_t;

   typedef struct packed {
      logic a_parity_err;
      logic b_parity_err;
      logic sar_parity_err;
      logic allow_write;
      logic ctrl_parity_err;
      logic sense_parity_err;
      logic next_addr_parity_err;
      logic w_parity;
      logic x_parity;
      logic r_parity_err;
      logic stack_parity_err;
      logic alu_err;
   } check_in_t;

   typedef struct packed {
      logic valid;
      logic parity_position;
      logic [7:0] x_low;
   } forced_entry_t;

endpackage

// ---- hw/machine_check_priority_entry.sv ----
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module machine_check_priority_entry
#(
   parameter logic [15:0] ALLOW_A_DECODES = 16'h00fe,
   parameter bit PROTECT_FITTED = 1'b1
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cycle phases and check sources
   input wire mc_pkg::phase_t phase,
   input wire mc_pkg::check_in_t checks,
   input wire logic [3:0] a_source_control_field,
   input wire logic d_to_a_bus,
   input wire logic parity_position,
   input wire logic check_reset,
   input wire logic machine_reset,
   // sequencer and channel side
   input wire logic [7:0] priority_mask,
   input wire logic [8:1] priority_request,
   input wire logic priority_release,
   input wire logic manual_wx_switch,
   output mc_pkg::forced_entry_t forced_entry,
   output logic machine_check_pulse,
   output logic [7:0] machine_check_register,
   output logic cycle_clock_stop
);

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [7:0] mc;
   logic [1:0] control;
   logic allow_a;
   logic suppress_a;
   logic first_mc;
   logic second_err;
   logic hard_stop;
   logic any_prio;
   logic prio_latch;
   logic manual_latch;
   logic [8:1] stack;
   logic mask1_prev;
   logic wx_sync1;
   logic wx_sync2;
   logic [7:0] next_mc;
   logic [8:1] pulse;
   logic any_pulse;
   logic csar_bad;
   logic a_check_ok;

   // low address byte forced by a one-hot level, bit 0 is the msb
   function automatic logic [7:0] x_of_level(input logic [8:1] one_hot);
      logic [7:0] x;
      x = 8'h00;
      if (one_hot[1]) x = mc_pkg::X_LEVEL1;
      if (one_hot[2]) x = mc_pkg::X_LEVEL2;
      if (one_hot[3]) x = mc_pkg::X_LEVEL3;
      if (one_hot[4]) x = mc_pkg::X_LEVEL4;
      if (one_hot[5]) x = mc_pkg::X_LEVEL5;
      if (one_hot[6]) x = mc_pkg::X_LEVEL6;
      if (one_hot[7]) x = mc_pkg::X_LEVEL7;
      if (one_hot[8]) x = mc_pkg::X_LEVEL8;
      return x;
   endfunction

   // -------------------------------------------------------------
   // switch synchroniser
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wx_sync1 <= 1'b0;
         wx_sync2 <= 1'b0;
      end
      else
      begin
         wx_sync1 <= manual_wx_switch;
         wx_sync2 <= wx_sync1;
      end
   end

   // -------------------------------------------------------------
   // check capture
   // -------------------------------------------------------------
   // parity-position takes part so an address forced by reset still checks
   assign csar_bad = ~(checks.w_parity ^ checks.x_parity ^ parity_position);
   assign a_check_ok = allow_a & ~suppress_a;

   always_comb
   begin
      next_mc = 8'h00;
      next_mc[7 - mc_pkg::MC_A] = phase.t3 & checks.a_parity_err & a_check_ok;
      next_mc[7 - mc_pkg::MC_B] = phase.t3 & checks.b_parity_err;
      next_mc[7 - mc_pkg::MC_SAR] = phase.t3 & checks.sar_parity_err & checks.allow_write;
      next_mc[7 - mc_pkg::MC_CTRL] = phase.t2 & checks.ctrl_parity_err;
      next_mc[7 - mc_pkg::MC_SENSE] = phase.t2
         & (checks.sense_parity_err | checks.next_addr_parity_err);
      next_mc[7 - mc_pkg::MC_CSAR] = phase.t2 & csar_bad;
      next_mc[7 - mc_pkg::MC_R] = checks.r_parity_err
         | (PROTECT_FITTED & checks.stack_parity_err);
      next_mc[7 - mc_pkg::MC_ALU] = phase.t4 & checks.alu_err;
   end

   // a new error beats the P4 reset in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mc <= mc_pkg::MC_RESET;
      else if (machine_reset)
         mc <= mc_pkg::MC_RESET;
      else if (phase.p4 && check_reset)
         mc <= next_mc;
      else
         mc <= mc | next_mc;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         allow_a <= 1'b0;
      else if (machine_reset)
         allow_a <= 1'b0;
      else if (phase.p1 && ALLOW_A_DECODES[a_source_control_field])
         allow_a <= 1'b1;
      else if (phase.t1 && suppress_a)
         allow_a <= 1'b0;
   end

   // the check routine reuses the faulty register; suppress until D rewrites it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         suppress_a <= 1'b0;
      else if (machine_reset)
         suppress_a <= 1'b0;
      else if (next_mc[7 - mc_pkg::MC_A])
         suppress_a <= 1'b1;
      else if (d_to_a_bus)
         suppress_a <= 1'b0;
   end

   // -------------------------------------------------------------
   // first check, second-error stop, hard stop
   // -------------------------------------------------------------
   // only fresh errors arm the entry, so a captured bit is not retaken forever
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         first_mc <= 1'b0;
      else if (machine_reset)
         first_mc <= 1'b0;
      else if ((|(next_mc & ~mc)) && control[mc_pkg::CTRL_PROCESS])
         first_mc <= 1'b1;
      else if (phase.p4 && check_reset)
         first_mc <= 1'b0;
      else if (machine_check_pulse)
         first_mc <= 1'b0;
   end

   assign machine_check_pulse = ~prio_latch & ~manual_latch & first_mc
      & ~control[mc_pkg::CTRL_SUPPRESS_MALF];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask1_prev <= 1'b0;
      else
         mask1_prev <= priority_mask[7 - mc_pkg::MASK_CHECK_HELD];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         second_err <= 1'b0;
      else if (machine_reset)
         second_err <= 1'b0;
      else if (machine_check_pulse)
         second_err <= 1'b1;
      else if (priority_mask[7 - mc_pkg::MASK_CHECK_HELD] && !mask1_prev)
         second_err <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hard_stop <= 1'b0;
      else if (machine_reset)
         hard_stop <= 1'b0;
      else if (machine_check_pulse && second_err)
         hard_stop <= 1'b1;
   end

   assign cycle_clock_stop = hard_stop;

   // -------------------------------------------------------------
   // priority stacking and arbitration
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stack <= 8'h00;
      else if (machine_reset)
         stack <= 8'h00;
      else
      begin
         for (int lvl = 2; lvl <= 8; lvl++)
         begin
            if (priority_request[lvl])
               stack[lvl] <= 1'b1;
            else if (pulse[lvl])
               stack[lvl] <= 1'b0;
         end
         if (priority_request[mc_pkg::LVL_SELECTOR]
             && priority_mask[7 - mc_pkg::MASK_SELECTOR])
            stack[mc_pkg::LVL_SELECTOR] <= 1'b0;
         if (priority_request[mc_pkg::LVL_SHARE]
             && (priority_mask[7 - mc_pkg::MASK_SHARE]
                 || priority_mask[7 - mc_pkg::MASK_SELECTOR]))
            stack[mc_pkg::LVL_SHARE] <= 1'b0;
         // the check level is fed by the first-check latch, not a stack
         stack[mc_pkg::LVL_CHECK] <= 1'b0;
      end
   end

   always_comb
   begin
      logic higher;
      higher = machine_reset;
      pulse = 8'h00;
      pulse[1] = machine_check_pulse & ~higher;
      higher = higher | pulse[1];
      for (int lvl = 2; lvl <= 8; lvl++)
      begin
         pulse[lvl] = ~prio_latch & ~manual_latch & ~higher & stack[lvl];
         if (lvl == mc_pkg::LVL_WRAP)
            pulse[lvl] = pulse[lvl] & ~priority_mask[7 - mc_pkg::MASK_WRAP];
         higher = higher | pulse[lvl];
      end
   end

   assign any_pulse = |pulse;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         any_prio <= 1'b0;
      else if (machine_reset)
         any_prio <= 1'b0;
      else if (phase.t1 && any_pulse)
         any_prio <= 1'b1;
      else if (priority_release || (phase.p4 && manual_latch))
         any_prio <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prio_latch <= 1'b0;
      else if (machine_reset)
         prio_latch <= 1'b0;
      else if (phase.t3 && any_prio)
         prio_latch <= 1'b1;
      else if (priority_release || (phase.p4 && manual_latch))
         prio_latch <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         manual_latch <= 1'b0;
      else if (phase.t1 && wx_sync2)
         manual_latch <= 1'b1;
      else if (phase.t1)
         manual_latch <= 1'b0;
   end

   // one-cycle forced address; a pulse clears its own source, so it loads once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         forced_entry <= '0;
      else if (machine_reset)
      begin
         forced_entry.valid <= 1'b1;
         forced_entry.parity_position <= 1'b1;
         forced_entry.x_low <= mc_pkg::X_MACHINE_RESET;
      end
      else if (any_pulse)
      begin
         forced_entry.valid <= 1'b1;
         forced_entry.parity_position <= 1'b0;
         forced_entry.x_low <= x_of_level(pulse);
      end
      else
         forced_entry.valid <= 1'b0;
   end

   assign machine_check_register = mc;

   // -------------------------------------------------------------
   // apb registers
   // -------------------------------------------------------------
   // no wait states: every access completes in its first access cycle
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         control <= mc_pkg::CONTROL_RESET;
      else if (psel && penable && pwrite && paddr == mc_pkg::ADDR_CONTROL)
         control <= pwdata[1:0];
   end

   always_comb
   begin
      pslverr = 1'b0;
      prdata = 32'h0000_0000;
      case (paddr)
         mc_pkg::ADDR_CAPTURE:
            prdata[7:0] = mc;
         mc_pkg::ADDR_CONTROL:
            prdata[1:0] = control;
         mc_pkg::ADDR_STATUS:
            prdata[7:0] = {manual_latch, suppress_a, allow_a, prio_latch,
                           any_prio, hard_stop, second_err, first_mc};
         mc_pkg::ADDR_STACK:
            prdata[16:0] = {forced_entry.parity_position, forced_entry.x_low,
                            stack};
         default:
            pslverr = psel & penable;
      endcase
   end

endmodule // machine_check_priority_entry

// ---- verification/mc_entry_assertions.sv ----
`timescale 1ns/1ps
module mc_entry_checker
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // check sources and controls
   input wire mc_pkg::phase_t phase,
   input wire mc_pkg::check_in_t checks,
   input wire logic parity_position,
   input wire logic check_reset,
   input wire logic machine_reset,
   // results
   input wire mc_pkg::forced_entry_t forced_entry,
   input wire logic machine_check_pulse,
   input wire logic [7:0] machine_check_register,
   input wire logic cycle_clock_stop
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // -------------------------------------------------------------
   // capture bits, bit 0 of the register sits at [7]
   // -------------------------------------------------------------
   AST_A_BIT: assert property ($rose(machine_check_register[7]) |->
      $past(phase.t3 && checks.a_parity_err)) else $error("a bit set without its cause");
   AST_B_BIT: assert property (phase.t3 && checks.b_parity_err && !machine_reset |=>
      machine_check_register[6]) else $error("b bit not set");
   AST_SAR_BIT: assert property ($rose(machine_check_register[5]) |->
      $past(phase.t3 && checks.sar_parity_err && checks.allow_write))
      else $error("storage address bit set without its cause");
   AST_CTRL_BIT: assert property (phase.t2 && checks.ctrl_parity_err && !machine_reset |=>
      machine_check_register[4]) else $error("control bit not set");
   AST_SENSE_BIT: assert property (phase.t2 && !machine_reset &&
      (checks.sense_parity_err || checks.next_addr_parity_err) |=> machine_check_register[3])
      else $error("sense bit not set");
   AST_ADDR_PARITY: assert property (phase.t2 && !machine_reset &&
      !(checks.w_parity ^ checks.x_parity ^ parity_position) |=> machine_check_register[2])
      else $error("address parity bit not set");
   AST_R_BIT: assert property ((checks.r_parity_err || checks.stack_parity_err) &&
      !machine_reset |=> machine_check_register[1]) else $error("r bit not set");
   AST_ALU_BIT: assert property (phase.t4 && checks.alu_err && !machine_reset |=>
      machine_check_register[0]) else $error("alu bit not set");
   AST_HOLD: assert property (!machine_reset && !(phase.p4 && check_reset) |=>
      (machine_check_register & $past(machine_check_register)) == $past(machine_check_register))
      else $error("capture bit lost without a clear");
   AST_CLEAR: assert property (phase.p4 && check_reset && (checks & 12'hfe7) == 12'h000 |=>
      machine_check_register == 8'h00) else $error("capture not cleared");

   // -------------------------------------------------------------
   // entries and stop
   // -------------------------------------------------------------
   AST_RESET_ENTRY: assert property (machine_reset |=> forced_entry.valid &&
      forced_entry.parity_position && forced_entry.x_low == mc_pkg::X_MACHINE_RESET &&
      machine_check_register == mc_pkg::MC_RESET && !cycle_clock_stop)
      else $error("machine reset entry wrong");
   AST_CHECK_ENTRY: assert property (forced_entry.valid && !forced_entry.parity_position &&
      forced_entry.x_low == mc_pkg::X_LEVEL1 |-> $past(machine_check_pulse))
      else $error("check entry without pulse");
   AST_STOP_HOLD: assert property (cycle_clock_stop && !machine_reset |=>
      cycle_clock_stop) else $error("hard stop dropped");
endmodule // mc_entry_checker

bind machine_check_priority_entry mc_entry_checker mc_entry_checker_i (.pclk(pclk),
   .presetn(presetn), .phase(phase), .checks(checks), .parity_position(parity_position),
   .check_reset(check_reset), .machine_reset(machine_reset), .forced_entry(forced_entry),
   .machine_check_pulse(machine_check_pulse), .machine_check_register(machine_check_register),
   .cycle_clock_stop(cycle_clock_stop));

// ---- verification/cycle_sequencer_model.sv ----
`timescale 1ns/1ps
module cycle_sequencer_model
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // from the block
   input wire logic cycle_clock_stop,
   input wire mc_pkg::forced_entry_t forced_entry,
   // to the block
   output mc_pkg::phase_t phase,
   output logic priority_release
);
   logic [5:0] ring;
   logic [3:0] hold;

   // the ring holds and all phases drop to zero while the block holds the cycle clock stopped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ring <= 6'h20;
      else if (!cycle_clock_stop)
         ring <= {ring[0], ring[5:1]};
   end
   assign phase = mc_pkg::phase_t'(cycle_clock_stop ? 6'h00 : ring);

   // the entered microprogram hands the priority back some cycles later
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hold <= 4'h0;
      else if (forced_entry.valid)
         hold <= 4'hc;
      else if (hold != 4'h0)
         hold <= hold - 4'h1;
   end
   assign priority_release = (hold == 4'h1);
endmodule // cycle_sequencer_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   mc_pkg::phase_t phase;
   logic [11:0] chk = 12'h008;
   logic [3:0] a_src = 4'h1;
   logic d_to_a_bus = 1'b0;
   logic parity_position = 1'b0;
   logic check_reset = 1'b0;
   logic machine_reset = 1'b0;
   logic [7:0] priority_mask = 8'h00;
   logic [8:1] priority_request = 8'h00;
   logic priority_release;
   logic manual_wx_switch = 1'b0;
   mc_pkg::forced_entry_t forced_entry;
   logic machine_check_pulse;
   logic [7:0] machine_check_register;
   logic cycle_clock_stop;
   int failures = 0;
   int check_count = 0;
   logic [31:0] seed = 32'h0000dd76;
   logic [31:0] q;
   logic e;
   logic hit;
   logic [7:0] x;
   logic [11:0] c;
   logic [7:0] m;
   logic p;
   int lvl;
   logic [11:0] tbl [0:10] = '{12'h808, 12'h408, 12'h308, 12'h208, 12'h088, 12'h048, 12'h028,
      12'h000, 12'h00c, 12'h00a, 12'h009};

   always #2 pclk = ~pclk;

   machine_check_priority_entry machine_check_priority_entry_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase(phase), .checks(chk),
      .a_source_control_field(a_src), .d_to_a_bus(d_to_a_bus), .parity_position(parity_position),
      .check_reset(check_reset), .machine_reset(machine_reset), .priority_mask(priority_mask),
      .priority_request(priority_request), .priority_release(priority_release),
      .manual_wx_switch(manual_wx_switch), .forced_entry(forced_entry),
      .machine_check_pulse(machine_check_pulse), .machine_check_register(machine_check_register),
      .cycle_clock_stop(cycle_clock_stop));

   cycle_sequencer_model cycle_sequencer_model_i (.pclk(pclk), .presetn(presetn),
      .cycle_clock_stop(cycle_clock_stop), .forced_entry(forced_entry), .phase(phase),
      .priority_release(priority_release));

   // -------------------------------------------------------------
   // expectations and helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // check inputs packed a,b,sar,write,ctrl,sense,next,w,x,r,stack,alu from the top
   function automatic logic [7:0] exp_mc(input logic [11:0] v, input logic pp);
      return {v[11], v[10], v[9] & v[8], v[7], v[6] | v[5], ~(v[4] ^ v[3] ^ pp), v[2] | v[1], v[0]};
   endfunction

   function automatic logic [8:0] exp_entry(input int l, input logic [7:0] k);
      logic [7:0] xb;
      case (l)
         2: xb = mc_pkg::X_LEVEL2;
         3: xb = mc_pkg::X_LEVEL3;
         4: xb = mc_pkg::X_LEVEL4;
         5: xb = mc_pkg::X_LEVEL5;
         6: xb = mc_pkg::X_LEVEL6;
         7: xb = mc_pkg::X_LEVEL7;
         default: xb = mc_pkg::X_LEVEL8;
      endcase
      if ((l == 2 && k[2]) || (l == 8 && (k[1] || k[2])) || (l == 4 && k[5]))
         return 9'h000;
      return {1'b1, xb};
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
      begin
         failures++;
         tally_and_finish();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // a machine reset entry carries the parity-position bit, so it is skipped here
   task automatic wait_entry(input int n);
      hit = 1'b0;
      x = 8'h00;
      for (int i = 0; i < n && !hit; i++)
      begin
         @(posedge pclk);
         if (forced_entry.valid === 1'b1 && forced_entry.parity_position === 1'b0)
         begin
            hit = 1'b1;
            x = forced_entry.x_low;
         end
      end
   endtask

   task automatic mreset();
      chk <= 12'h008;
      parity_position <= 1'b0;
      @(posedge pclk);
      machine_reset <= 1'b1;
      @(posedge pclk);
      machine_reset <= 1'b0;
      @(posedge pclk);
      cmp({22'h0, forced_entry}, {22'h0, 2'b11, mc_pkg::X_MACHINE_RESET});
      cmp({31'h0, cycle_clock_stop}, 32'h0);
   endtask

   // six cycles hold the clear across one full phase ring, so one p4 is met
   task automatic clr();
      check_reset <= 1'b1;
      repeat (6) @(posedge pclk);
      check_reset <= 1'b0;
   endtask

   task automatic inject(input logic [11:0] v, input int n);
      @(posedge pclk);
      d_to_a_bus <= 1'b1;
      a_src <= 4'h1 + 4'(rnd() % 7);
      @(posedge pclk);
      d_to_a_bus <= 1'b0;
      chk <= v;
      parity_position <= p;
      repeat (n) @(posedge pclk);
      chk <= 12'h008;
      parity_position <= 1'b0;
   endtask

   // -------------------------------------------------------------
   // run
   // -------------------------------------------------------------
   initial
   begin
      repeat (50000) @(posedge pclk);
      failures++;
      tally_and_finish();
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         cmp(q, (i == 1) ? 32'h1 : (i == 2) ? 32'h20 : 32'h0);
         cmp({31'h0, e}, 32'h0);
      end
      apb(1'b1, mc_pkg::ADDR_CAPTURE, 32'hff);
      apb(1'b0, mc_pkg::ADDR_CAPTURE, 32'h0);
      cmp(q, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      cmp({31'h0, e}, 32'h1);
      $display("test registers done");

      apb(1'b1, mc_pkg::ADDR_CONTROL, 32'h3);
      for (int i = 0; i < 19; i++)
      begin
         c = (i < 11) ? tbl[i] : 12'(rnd());
         p = (i < 11) ? 1'b0 : rnd() & 32'h1;
         inject(c, 12);
         apb(1'b0, mc_pkg::ADDR_CAPTURE, 32'h0);
         cmp(q, {24'h0, exp_mc(c, p)});
         apb(1'b0, mc_pkg::ADDR_STATUS, 32'h0);
         cmp({31'h0, q[0]}, {31'h0, |exp_mc(c, p)});
         clr();
         apb(1'b0, mc_pkg::ADDR_CAPTURE, 32'h0);
         cmp(q, 32'h0);
      end
      $display("test capture done");

      mreset();
      apb(1'b1, mc_pkg::ADDR_CONTROL, 32'h1);
      for (int k = 0; k < 3; k++)
      begin
         clr();
         repeat (16) @(posedge pclk);
         chk <= 12'h408;
         wait_entry(30);
         chk <= 12'h008;
         repeat (4) @(posedge pclk);
         cmp({31'h0, cycle_clock_stop}, {31'h0, k == 2});
         if (k < 2)
         begin
            cmp({23'h0, hit, x}, {24'h1, mc_pkg::X_LEVEL1});
            apb(1'b0, mc_pkg::ADDR_STATUS, 32'h0);
            cmp(q & 32'h6, 32'h2);
         end
         if (k == 0)
         begin
            priority_mask <= 8'h40;
            apb(1'b0, mc_pkg::ADDR_STATUS, 32'h0);
            cmp(q & 32'h2, 32'h0);
         end
      end
      repeat (30) @(posedge pclk);
      cmp({31'h0, cycle_clock_stop}, 32'h1);
      $display("test check entry done");

      for (int i = 0; i < 14; i++)
      begin
         lvl = 2 + i % 7;
         m = (i < 7) ? 8'h00 : 8'(rnd());
         mreset();
         priority_mask <= m;
         priority_request[lvl] <= 1'b1;
         @(posedge pclk);
         priority_request[lvl] <= 1'b0;
         wait_entry(24);
         cmp({23'h0, hit, x}, {23'h0, exp_entry(lvl, m)});
      end
      $display("test priority done");
      tally_and_finish();
   end
endmodule // tb_top
